// ==== vtr_pkg.sv ====
/*
 * Shared constants for the VLAN tag and route classifier: register map,
 * reset values, tag kinds, pipeline actions and pipeline points.
 * Assumes a single 100 MHz core clock and 32-bit register data.
 */
package vtr_pkg;

   // Register map (byte addresses)
   localparam logic [7:0]  VTR_CUSTOM_TPID0_OFS = 8'h00;
   localparam logic [7:0]  VTR_CUSTOM_TPID1_OFS = 8'h04;
   localparam logic [7:0]  VTR_CUSTOM_TPID2_OFS = 8'h08;
   localparam logic [7:0]  VTR_STATUS_OFS       = 8'h0c;
   localparam logic [7:0]  VTR_PORT_BASE_OFS    = 8'h20;
   localparam int          VTR_PORT_STRIDE_LSB  = 2;

   // Field positions inside a port_tpid_ctrl word
   localparam int          VTR_MASK_LSB         = 0;
   localparam int          VTR_MASK_W           = 15;
   localparam int          VTR_CNT_SEL_LSB      = 16;
   localparam int          VTR_CNT_SEL_W        = 4;
   localparam int          VTR_KINDS_PER_POS    = 5;
   localparam int          VTR_MAX_TAGS         = 3;

   // Values after reset
   localparam logic [15:0] VTR_CUSTOM_TPID_RST  = 16'hffff;
   localparam logic [14:0] VTR_MASK_RST         = 15'h0000;
   localparam logic [3:0]  VTR_CNT_SEL_RST      = 4'h0;

   // Fixed protocol identifiers
   localparam logic [15:0] VTR_CTAG_TPID        = 16'h8100;
   localparam logic [15:0] VTR_STAG_TPID        = 16'h88a8;
   localparam logic [15:0] VTR_IPV4_TYPE        = 16'h0800;
   localparam logic [15:0] VTR_IPV6_TYPE        = 16'h86dd;

   // Recognised tag kinds; zero means no tag
   typedef enum logic [2:0] {
      VTR_KIND_NONE   = 3'h0,
      VTR_KIND_CTAG   = 3'h1,
      VTR_KIND_STAG   = 3'h2,
      VTR_KIND_CUST0  = 3'h3,
      VTR_KIND_CUST1  = 3'h4,
      VTR_KIND_CUST2  = 3'h5
   } vtr_kind_type;

   // Pipeline actions carried with the frame
   typedef enum logic [1:0] {
      VTR_ACT_NONE     = 2'h0,
      VTR_ACT_INJECT   = 2'h1,
      VTR_ACT_EXTRACT  = 2'h2,
      VTR_ACT_LOOPBACK = 2'h3   // rewriter_loopback_action
   } vtr_action_type;

   // Pipeline points in flow order; analyzer points precede rewriter points
   typedef enum logic [3:0] {
      VTR_PT_NONE              = 4'h0,
      VTR_PT_AN_PORT_OAM       = 4'h1,
      VTR_PT_AN_OUTER_OAM      = 4'h2,
      VTR_PT_AN_INNER_OAM      = 4'h3,
      VTR_PT_INGRESS_CLASSIFIER = 4'h4,
      VTR_PT_AN_TCAM_CLASS     = 4'h5,
      VTR_PT_AN_OUTER_SWITCH   = 4'h6,
      VTR_PT_AN_INNER_SWITCH   = 4'h7,
      VTR_PT_RW_INNER_SWITCH   = 4'h8,
      VTR_PT_RW_OUTER_SWITCH   = 4'h9,
      VTR_PT_RW_INNER_OAM      = 4'ha,
      VTR_PT_RW_OUTER_OAM      = 4'hb,
      VTR_PT_RW_PORT_OAM       = 4'hc,
      VTR_PT_RW_SAT            = 4'hd
   } vtr_point_type;

endpackage

// ==== vtr_tag_match.sv ====
/*
 * Tag protocol identifier matcher: turns one 16-bit type word into a
 * recognised tag kind. Purely combinational; the caller registers it.
 * Assumes the custom identifiers are stable register values.
 */
`timescale 1ns/1ps
module vtr_tag_match #(
   parameter int W = 16
) (
   // Type word under test
   input  wire logic [W-1:0]             type_word,
   // Programmed custom identifiers
   input  wire logic [W-1:0]             custom0,
   input  wire logic [W-1:0]             custom1,
   input  wire logic [W-1:0]             custom2,
   // Result
   output vtr_pkg::vtr_kind_type         kind
);
   import vtr_pkg::*;

   // Fixed identifiers win over custom ones if software programs a duplicate
   always_comb begin
      // RL1 customer tag
      if (type_word == VTR_CTAG_TPID) begin
         kind = VTR_KIND_CTAG;
      // RL2 service tag
      end else if (type_word == VTR_STAG_TPID) begin
         kind = VTR_KIND_STAG;
      // RL3 custom service tags
      end else if (type_word == custom0) begin
         kind = VTR_KIND_CUST0;
      end else if (type_word == custom1) begin
         kind = VTR_KIND_CUST1;
      end else if (type_word == custom2) begin
         kind = VTR_KIND_CUST2;
      end else begin
         kind = VTR_KIND_NONE;
      end
   end

endmodule // vtr_tag_match

// ==== vtr_pipe_xlate.sv ====
/*
 * Pipeline point evaluation: translates rewriter points of looped frames
 * into analyzer points and decides whether the classifier acts on the
 * frame. Combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module vtr_pipe_xlate (
   // Frame pipeline information
   input  vtr_pkg::vtr_action_type       action,
   input  vtr_pkg::vtr_point_type        point,
   // Results
   output vtr_pkg::vtr_point_type        point_out,
   output logic                          active
);
   import vtr_pkg::*;

   // RL7 loopback point replacement
   always_comb begin
      point_out = point;
      if (action == VTR_ACT_LOOPBACK) begin
         unique case (point)
            // RL8 analyzer equivalents
            VTR_PT_RW_PORT_OAM:     point_out = VTR_PT_AN_PORT_OAM;
            VTR_PT_RW_OUTER_OAM:    point_out = VTR_PT_AN_OUTER_OAM;
            VTR_PT_RW_INNER_OAM:    point_out = VTR_PT_AN_INNER_OAM;
            VTR_PT_RW_SAT:          point_out = VTR_PT_AN_TCAM_CLASS;
            VTR_PT_RW_INNER_SWITCH: point_out = VTR_PT_AN_INNER_SWITCH;
            // RL9 outer switch mapping
            VTR_PT_RW_OUTER_SWITCH: point_out = VTR_PT_AN_OUTER_SWITCH;
            default:                point_out = point;
         endcase
      end
   end

   // RL6 classifier activity; a looped frame re-enters like an injected one
   always_comb begin
      unique case (action)
         VTR_ACT_NONE:     active = 1'b1;
         VTR_ACT_INJECT:   active = (point <= VTR_PT_INGRESS_CLASSIFIER);
         VTR_ACT_EXTRACT:  active = (point >= VTR_PT_INGRESS_CLASSIFIER);
         VTR_ACT_LOOPBACK: active = (point_out <= VTR_PT_INGRESS_CLASSIFIER);
         default:          active = 1'b1;
      endcase
      if (point == VTR_PT_NONE) begin
         active = 1'b1;
      end
   end

endmodule // vtr_pipe_xlate

// ==== vtr_classifier.sv ====
/*
 * VLAN tag and route classifier, front stage of the ingress classifier.
 * Takes one parsed frame header per hdr_valid pulse and gives the result
 * one clock later. Registers are reached over a plain strobe port.
 * Assumes the upstream parser gives the four type words that follow the
 * source address and the tag control words of the first three tags.
 */
// Implementation choices: the address map and the plain strobed port.
// How it works
// RL1 - 0x8100 identifies a customer tag
// RL2 - 0x88A8 identifies a service tag
// RL3 - Three programmable custom service tag identifiers
// RL4 - Parse and pass on three tags
// RL5 - More than three tags means non-IP
// RL6 - Active unless injected late or extracted early
// RL7 - Loopback swaps rewriter point for analyzer point
// RL8 - Map port, OAM, SAT, inner switch points
// RL9 - Rewriter outer switch maps to analyzer outer
// RL10 - Flag routable IP frames to routing stage
// RL11 - Routable needs valid tags and enabled count
// RL12 - Per-port validity per tag position
// RL13 - Five disable bits per position, fifteen total
// RL14 - Count select bit per tag count
// RL15 - Untagged routable only if bit zero set
`timescale 1ns/1ps
module vtr_classifier #(
   parameter int NUM_PORTS = 8,
   parameter int PORT_W    = 3
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   // Register port
   input  wire logic [7:0]               reg_addr,
   input  wire logic [31:0]              reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic [31:0]                   reg_rdata,
   // Parsed frame header
   input  wire logic                     hdr_valid,
   input  wire logic [PORT_W-1:0]        hdr_port,
   input  wire logic [15:0]              hdr_type0,
   input  wire logic [15:0]              hdr_type1,
   input  wire logic [15:0]              hdr_type2,
   input  wire logic [15:0]              hdr_type3,
   input  wire logic [15:0]              hdr_tci0,
   input  wire logic [15:0]              hdr_tci1,
   input  wire logic [15:0]              hdr_tci2,
   input  vtr_pkg::vtr_action_type       hdr_pipeline_action,
   input  vtr_pkg::vtr_point_type        hdr_pipeline_point,
   // Classification result
   output logic                          res_valid,
   output logic [1:0]                    res_tag_count,
   output logic                          res_too_many_tags,
   output vtr_pkg::vtr_kind_type         res_kind0,
   output vtr_pkg::vtr_kind_type         res_kind1,
   output vtr_pkg::vtr_kind_type         res_kind2,
   output logic [15:0]                   res_tci0,
   output logic [15:0]                   res_tci1,
   output logic [15:0]                   res_tci2,
   output logic                          res_is_ip,
   output logic                          res_routable,
   output logic                          res_active,
   output vtr_pkg::vtr_point_type        res_pipeline_point
);
   import vtr_pkg::*;

   // Configuration state
   logic [15:0]              custom_tpid [VTR_MAX_TAGS];
   logic [VTR_MASK_W-1:0]    tpid_route_invalid_mask [NUM_PORTS];
   logic [VTR_CNT_SEL_W-1:0] routable_tag_count_sel [NUM_PORTS];
   logic [15:0]              frame_count;
   logic [15:0]              routable_count;

   // Register decode
   wire logic [PORT_W-1:0]   reg_port  = reg_addr[VTR_PORT_STRIDE_LSB +: PORT_W];
   wire logic                port_area = (reg_addr[7:5] == VTR_PORT_BASE_OFS[7:5]) &&
                                         (reg_addr[1:0] == 2'h0) &&
                                         (32'(reg_port) < NUM_PORTS);
   wire logic                hit_tpid0 = (reg_addr == VTR_CUSTOM_TPID0_OFS);
   wire logic                hit_tpid1 = (reg_addr == VTR_CUSTOM_TPID1_OFS);
   wire logic                hit_tpid2 = (reg_addr == VTR_CUSTOM_TPID2_OFS);
   wire logic                hit_stat  = (reg_addr == VTR_STATUS_OFS);

   // Read mux; unmapped addresses read as zero
   wire logic [31:0]         port_word = {12'h000,
                                          routable_tag_count_sel[reg_port],
                                          1'b0,
                                          tpid_route_invalid_mask[reg_port]};
   wire logic [31:0]         read_mux  = hit_tpid0 ? {16'h0000, custom_tpid[0]} :
                                         hit_tpid1 ? {16'h0000, custom_tpid[1]} :
                                         hit_tpid2 ? {16'h0000, custom_tpid[2]} :
                                         hit_stat  ? {routable_count, frame_count} :
                                         port_area ? port_word : 32'h0000_0000;

   // Custom identifier writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < VTR_MAX_TAGS; i++) begin
            custom_tpid[i] <= VTR_CUSTOM_TPID_RST;
         end
      end else if (reg_wr) begin
         // RL3 programmable identifiers
         if (hit_tpid0) custom_tpid[0] <= reg_wdata[15:0];
         if (hit_tpid1) custom_tpid[1] <= reg_wdata[15:0];
         if (hit_tpid2) custom_tpid[2] <= reg_wdata[15:0];
      end
   end

   // Per-port routing controls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            tpid_route_invalid_mask[p] <= VTR_MASK_RST;
            routable_tag_count_sel[p]  <= VTR_CNT_SEL_RST;
         end
      end else if (reg_wr && port_area) begin
         // RL12 per-port validity store
         tpid_route_invalid_mask[reg_port] <= reg_wdata[VTR_MASK_LSB +: VTR_MASK_W];
         routable_tag_count_sel[reg_port]  <= reg_wdata[VTR_CNT_SEL_LSB +: VTR_CNT_SEL_W];
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else begin
         reg_rdata <= reg_rd ? read_mux : 32'h0000_0000;
      end
   end

   // Tag recognition, one matcher per type word
   vtr_kind_type kind [4];
   wire logic [15:0] type_word [4] = '{hdr_type0, hdr_type1, hdr_type2, hdr_type3};

   for (genvar g = 0; g < 4; g++) begin : g_match
      vtr_tag_match #(
         .W (16)
      ) u_match (
         .type_word (type_word[g]),
         .custom0   (custom_tpid[0]),
         .custom1   (custom_tpid[1]),
         .custom2   (custom_tpid[2]),
         .kind      (kind[g])
      );
   end

   // RL4 consecutive tags only count from the outermost
   wire logic present0 = (kind[0] != VTR_KIND_NONE);
   wire logic present1 = present0 && (kind[1] != VTR_KIND_NONE);
   wire logic present2 = present1 && (kind[2] != VTR_KIND_NONE);
   // RL5 a fourth tag marks the frame
   wire logic too_many = present2 && (kind[3] != VTR_KIND_NONE);
   wire logic [1:0] tag_count = present2 ? 2'h3 :
                                present1 ? 2'h2 :
                                present0 ? 2'h1 : 2'h0;

   // Ethertype behind the last tag
   wire logic [15:0] inner_type = present2 ? hdr_type3 :
                                  present1 ? hdr_type2 :
                                  present0 ? hdr_type1 : hdr_type0;
   // RL5 non-IP beyond three tags
   wire logic is_ip = !too_many &&
                      ((inner_type == VTR_IPV4_TYPE) || (inner_type == VTR_IPV6_TYPE));

   // Tag validity for routing at one position
   function automatic logic tag_allowed(input logic [VTR_KINDS_PER_POS-1:0] row,
                                        input vtr_kind_type k,
                                        input logic present);
      logic ok;
      ok = 1'b1;
      // RL13 one disable bit per kind, customer tag lowest
      unique case (k)
         VTR_KIND_CTAG:  ok = !row[0];
         VTR_KIND_STAG:  ok = !row[1];
         VTR_KIND_CUST0: ok = !row[2];
         VTR_KIND_CUST1: ok = !row[3];
         VTR_KIND_CUST2: ok = !row[4];
         default:        ok = 1'b1;
      endcase
      return ok || !present;
   endfunction

   wire logic [VTR_MASK_W-1:0]    port_mask = tpid_route_invalid_mask[hdr_port];
   wire logic [VTR_CNT_SEL_W-1:0] port_sel  = routable_tag_count_sel[hdr_port];

   // RL12 each position uses its own five bits
   wire logic ok0 = tag_allowed(port_mask[0 +: VTR_KINDS_PER_POS], kind[0], present0);
   wire logic ok1 = tag_allowed(port_mask[5 +: VTR_KINDS_PER_POS], kind[1], present1);
   wire logic ok2 = tag_allowed(port_mask[10 +: VTR_KINDS_PER_POS], kind[2], present2);

   // RL14 count select bit; RL15 bit zero for untagged
   wire logic count_ok = port_sel[tag_count];

   // RL11 all tags valid and count enabled
   wire logic routable = is_ip && ok0 && ok1 && ok2 && count_ok;

   // Pipeline point evaluation
   vtr_point_type xlated_point;
   logic          active;

   vtr_pipe_xlate u_xlate (
      .action    (hdr_pipeline_action),
      .point     (hdr_pipeline_point),
      .point_out (xlated_point),
      .active    (active)
   );

   // Result valid pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_valid <= 1'b0;
      end else begin
         res_valid <= hdr_valid;
      end
   end

   // RL4 tag information to later stages
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_tag_count     <= 2'h0;
         res_too_many_tags <= 1'b0;
         res_kind0         <= VTR_KIND_NONE;
         res_kind1         <= VTR_KIND_NONE;
         res_kind2         <= VTR_KIND_NONE;
         res_tci0          <= 16'h0000;
         res_tci1          <= 16'h0000;
         res_tci2          <= 16'h0000;
      end else if (hdr_valid) begin
         res_tag_count     <= tag_count;
         res_too_many_tags <= too_many;
         res_kind0         <= present0 ? kind[0] : VTR_KIND_NONE;
         res_kind1         <= present1 ? kind[1] : VTR_KIND_NONE;
         res_kind2         <= present2 ? kind[2] : VTR_KIND_NONE;
         res_tci0          <= present0 ? hdr_tci0 : 16'h0000;
         res_tci1          <= present1 ? hdr_tci1 : 16'h0000;
         res_tci2          <= present2 ? hdr_tci2 : 16'h0000;
      end
   end

   // RL10 routable flag to routing stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         res_is_ip          <= 1'b0;
         res_routable       <= 1'b0;
         res_active         <= 1'b0;
         res_pipeline_point <= VTR_PT_NONE;
      end else if (hdr_valid) begin
         res_is_ip          <= is_ip;
         res_routable       <= routable;
         // RL6 activity decision
         res_active         <= active;
         // RL7 translated point
         res_pipeline_point <= xlated_point;
      end
   end

   // Frame statistics, wrap silently; software reads them as a pair
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_count    <= 16'h0000;
         routable_count <= 16'h0000;
      end else if (hdr_valid) begin
         frame_count    <= frame_count + 16'h0001;
         if (routable) begin
            routable_count <= routable_count + 16'h0001;
         end
      end
   end

endmodule // vtr_classifier

// ==== vtr_classifier_asserts.sv ====
/*
 * Port assertions for the classifier, bound below.
 * Assumes one core clock and an async active-low reset.
 */
`timescale 1ns/1ps
module vtr_classifier_asserts
   import vtr_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rst_n,
   // Register port
   input  wire logic               reg_rd,
   input  wire logic [31:0]        reg_rdata,
   // Frame header
   input  wire logic               hdr_valid,
   input  wire logic [15:0]        hdr_type0,
   input  vtr_pkg::vtr_action_type hdr_pipeline_action,
   input  vtr_pkg::vtr_point_type  hdr_pipeline_point,
   // Result
   input  wire logic               res_valid,
   input  wire logic [1:0]         res_tag_count,
   input  wire logic               res_too_many_tags,
   input  vtr_pkg::vtr_kind_type   res_kind0,
   input  wire logic               res_is_ip,
   input  wire logic               res_routable,
   input  wire logic               res_active,
   input  vtr_pkg::vtr_point_type  res_pipeline_point
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Looped frame at a given rewriter point
   sequence s_loop(vtr_point_type p);
      hdr_valid && hdr_pipeline_action == VTR_ACT_LOOPBACK && hdr_pipeline_point == p;
   endsequence

   // Result pulse one cycle after each header
   valid_follow_a: assert property (hdr_valid |=> res_valid)
      else $error("no result pulse");
   valid_alone_a: assert property (!hdr_valid |=> !res_valid)
      else $error("stray result pulse");
   result_hold_a: assert property (!hdr_valid |=> $stable(res_tag_count) && $stable(res_kind0))
      else $error("result changed idle");
   ctag_kind_a: assert property (hdr_valid && hdr_type0 == VTR_CTAG_TPID |=> res_kind0 == VTR_KIND_CTAG)
      else $error("customer tag missed");
   stag_kind_a: assert property (hdr_valid && hdr_type0 == VTR_STAG_TPID |=> res_kind0 == VTR_KIND_STAG)
      else $error("service tag missed");
   too_many_a: assert property (res_valid && res_too_many_tags |-> !res_is_ip && !res_routable)
      else $error("four tags seen as IP");
   loop_sat_a: assert property (s_loop(VTR_PT_RW_SAT) |=> res_pipeline_point == VTR_PT_AN_TCAM_CLASS)
      else $error("SAT point kept");
   loop_outer_a: assert property (s_loop(VTR_PT_RW_OUTER_SWITCH) |=> res_pipeline_point == VTR_PT_AN_OUTER_SWITCH)
      else $error("outer switch point kept");
   no_action_a: assert property (hdr_valid && hdr_pipeline_action == VTR_ACT_NONE |=> res_active)
      else $error("plain frame skipped");
   late_inject_a: assert property (hdr_valid && hdr_pipeline_action == VTR_ACT_INJECT
      && hdr_pipeline_point > VTR_PT_INGRESS_CLASSIFIER |=> !res_active)
      else $error("late inject processed");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("stray read data");
endmodule // vtr_classifier_asserts

bind vtr_classifier vtr_classifier_asserts u_asserts (.clk(clk), .rst_n(rst_n),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr_type0(hdr_type0),
   .hdr_pipeline_action(hdr_pipeline_action), .hdr_pipeline_point(hdr_pipeline_point),
   .res_valid(res_valid), .res_tag_count(res_tag_count), .res_too_many_tags(res_too_many_tags),
   .res_kind0(res_kind0), .res_is_ip(res_is_ip), .res_routable(res_routable),
   .res_active(res_active), .res_pipeline_point(res_pipeline_point));

// ==== vtr_route_sink.sv ====
/*
 * Routing stage model: counts results and routable flags.
 * Assumes res_valid qualifies each result.
 */
`timescale 1ns/1ps
module vtr_route_sink (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Classification result
   input  wire logic        res_valid,
   input  wire logic        res_routable,
   // Counts seen
   output logic [15:0]      frames,
   output logic [15:0]      routed
);
   // Flag only counts in the pulse cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frames <= 16'h0;
         routed <= 16'h0;
      end else if (res_valid) begin
         frames <= frames + 16'h1;
         routed <= routed + {15'h0, res_routable};
      end
   end
endmodule // vtr_route_sink

// ==== vtr_classifier_tb_top.sv ====
/*
 * Bench for the classifier: register tasks and frame sends.
 * Assumes a 100 MHz clock and one-cycle result latency.
 */
`timescale 1ns/1ps
module vtr_classifier_tb_top;
   import vtr_pkg::*;
   logic clk, rst_n, reg_wr, reg_rd, hdr_valid, res_valid, res_too_many_tags;
   logic res_is_ip, res_routable, res_active;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0]  hdr_port;
   logic [15:0] hdr_type0, hdr_type1, hdr_type2, hdr_type3, hdr_tci0, hdr_tci1, hdr_tci2;
   logic [15:0] res_tci0, res_tci1, res_tci2, frames, routed;
   logic [1:0]  res_tag_count;
   vtr_action_type hdr_pipeline_action;
   vtr_point_type  hdr_pipeline_point, res_pipeline_point;
   vtr_kind_type   res_kind0, res_kind1, res_kind2;
   logic [15:0] tpid_tab [5] = '{16'h8100, 16'h88a8, 16'h9100, 16'h9200, 16'h9300};
   logic [10:0] pipe_tab [11] = '{
      {VTR_ACT_NONE, VTR_PT_AN_TCAM_CLASS, VTR_PT_AN_TCAM_CLASS, 1'b1},
      {VTR_ACT_INJECT, VTR_PT_INGRESS_CLASSIFIER, VTR_PT_INGRESS_CLASSIFIER, 1'b1},
      {VTR_ACT_INJECT, VTR_PT_AN_TCAM_CLASS, VTR_PT_AN_TCAM_CLASS, 1'b0},
      {VTR_ACT_EXTRACT, VTR_PT_INGRESS_CLASSIFIER, VTR_PT_INGRESS_CLASSIFIER, 1'b1},
      {VTR_ACT_EXTRACT, VTR_PT_AN_INNER_OAM, VTR_PT_AN_INNER_OAM, 1'b0},
      {VTR_ACT_LOOPBACK, VTR_PT_RW_PORT_OAM, VTR_PT_AN_PORT_OAM, 1'b1},
      {VTR_ACT_LOOPBACK, VTR_PT_RW_OUTER_OAM, VTR_PT_AN_OUTER_OAM, 1'b1},
      {VTR_ACT_LOOPBACK, VTR_PT_RW_INNER_OAM, VTR_PT_AN_INNER_OAM, 1'b1},
      {VTR_ACT_LOOPBACK, VTR_PT_RW_SAT, VTR_PT_AN_TCAM_CLASS, 1'b0},
      {VTR_ACT_LOOPBACK, VTR_PT_RW_INNER_SWITCH, VTR_PT_AN_INNER_SWITCH, 1'b0},
      {VTR_ACT_LOOPBACK, VTR_PT_RW_OUTER_SWITCH, VTR_PT_AN_OUTER_SWITCH, 1'b0}};
   // Routing cases: port word, three type words, routable expected
   logic [80:0] rt_tab [8] = '{
      {32'h0002_7ffe, 16'h8100, 16'h0800, 16'h0, 1'b1},
      {32'h0002_7ffe, 16'h88a8, 16'h0800, 16'h0, 1'b0},
      {32'h0002_7ffe, 16'h8100, 16'h8100, 16'h0800, 1'b0},
      {32'h0002_7ffe, 16'h0800, 16'h0, 16'h0, 1'b0},
      {32'h0001_0000, 16'h0800, 16'h0, 16'h0, 1'b1},
      {32'h0001_0000, 16'h8100, 16'h0800, 16'h0, 1'b0},
      {32'h0004_7fde, 16'h8100, 16'h8100, 16'h0800, 1'b1},
      {32'h0004_7fde, 16'h8100, 16'h88a8, 16'h0800, 1'b0}};
   int miscompares = 0;
   int compares = 0;

   vtr_classifier #(.NUM_PORTS(8), .PORT_W(3)) uut (.clk(clk), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr_port(hdr_port),
      .hdr_type0(hdr_type0), .hdr_type1(hdr_type1), .hdr_type2(hdr_type2),
      .hdr_type3(hdr_type3), .hdr_tci0(hdr_tci0), .hdr_tci1(hdr_tci1), .hdr_tci2(hdr_tci2),
      .hdr_pipeline_action(hdr_pipeline_action), .hdr_pipeline_point(hdr_pipeline_point),
      .res_valid(res_valid), .res_tag_count(res_tag_count),
      .res_too_many_tags(res_too_many_tags), .res_kind0(res_kind0), .res_kind1(res_kind1),
      .res_kind2(res_kind2), .res_tci0(res_tci0), .res_tci1(res_tci1), .res_tci2(res_tci2),
      .res_is_ip(res_is_ip), .res_routable(res_routable), .res_active(res_active),
      .res_pipeline_point(res_pipeline_point));

   vtr_route_sink sink (.clk(clk), .rst_n(rst_n), .res_valid(res_valid),
      .res_routable(res_routable), .frames(frames), .routed(routed));

   // Free-running core clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string name, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // Answer stands one cycle after the strobe
   task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      check("reg_rdata", reg_rdata, exp);
   endtask

   task automatic frame(input logic [15:0] t0, t1, t2, t3, input logic [10:0] pp);
      @(posedge clk);
      hdr_valid <= 1'b1;
      hdr_type0 <= t0;
      hdr_type1 <= t1;
      hdr_type2 <= t2;
      hdr_type3 <= t3;
      hdr_pipeline_action <= vtr_action_type'(pp[10:9]);
      hdr_pipeline_point <= vtr_point_type'(pp[8:5]);
      @(posedge clk);
      hdr_valid <= 1'b0;
      #1;
      check("res_valid", 32'(res_valid), 32'h1);
   endtask

   task automatic tally_and_finish;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // A hang still ends in the verdict
   initial begin
      #200000;
      miscompares++;
      tally_and_finish;
   end

   // Main sequence
   initial begin
      {rst_n, reg_wr, reg_rd, hdr_valid, reg_addr, reg_wdata, hdr_port} = '0;
      {hdr_type0, hdr_type1, hdr_type2, hdr_type3} = '0;
      {hdr_tci0, hdr_tci1, hdr_tci2} = {16'h1a01, 16'h2b02, 16'h3c03};
      hdr_pipeline_action = VTR_ACT_NONE;
      hdr_pipeline_point = VTR_PT_NONE;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      reg_read(VTR_CUSTOM_TPID2_OFS, 32'h0000_ffff);
      reg_read(VTR_PORT_BASE_OFS, 32'h0);
      reg_read(8'h10, 32'h0);
      $display("test reset_values done");
      for (int i = 0; i < 3; i++) begin
         reg_write(VTR_CUSTOM_TPID0_OFS + 8'(4 * i), 32'(tpid_tab[i + 2]));
      end
      reg_read(VTR_CUSTOM_TPID1_OFS, 32'h0000_9200);
      // Each kind in the outer position
      for (int i = 0; i < 5; i++) begin
         frame(tpid_tab[i], VTR_IPV4_TYPE, 16'h0, 16'h0, 11'h0);
         check("res_kind0", 32'(res_kind0), 32'(i + 1));
         check("res_is_ip", 32'({res_tci1, res_tag_count, res_is_ip}), 32'h3);
      end
      $display("test tag_kinds done");
      frame(16'h8100, 16'h88a8, 16'h9100, VTR_IPV6_TYPE, 11'h0);
      check("three_tags", 32'({res_tag_count, res_kind1, res_kind2, res_is_ip}), 32'h1a7);
      check("res_tci", {res_tci0, res_tci2}, 32'h1a01_3c03);
      frame(16'h8100, 16'h8100, 16'h8100, 16'h8100, 11'h0);
      check("four_tags", 32'({res_too_many_tags, res_is_ip, res_routable}), 32'h4);
      $display("test tag_depth done");
      for (int i = 0; i < 11; i++) begin
         frame(VTR_IPV4_TYPE, 16'h0, 16'h0, 16'h0, pipe_tab[i]);
         check("point", 32'(res_pipeline_point), 32'(pipe_tab[i][4:1]));
         check("active", 32'(res_active), 32'(pipe_tab[i][0]));
      end
      $display("test pipeline_points done");
      for (int i = 0; i < 8; i++) begin
         reg_write(VTR_PORT_BASE_OFS, rt_tab[i][80:49]);
         frame(rt_tab[i][48:33], rt_tab[i][32:17], rt_tab[i][16:1], 16'h0, 11'h0);
         check("routable", 32'(res_routable), 32'(rt_tab[i][0]));
      end
      $display("test routing done");
      // 26 frames, 3 routable
      reg_read(VTR_STATUS_OFS, {16'd3, 16'd26});
      check("sink_counts", {routed, frames}, {16'd3, 16'd26});
      $display("test status done");
      tally_and_finish;
   end
endmodule // vtr_classifier_tb_top
